// file: inc/ccrb_pkg.sv
// Purpose: constants and types of the codec register and coefficient ram block
// Assumes: byte wide microcontroller access, one system clock
// Notes: field positions are bit indices inside the byte registers
//
// Functional notes
// - Extended operation code 6 carries five bytes: output amplifier control, then four loudspeaker coefficients.
// - Configuration registers 60h..6Eh and coefficient ram 80h..FFh are read and written directly; status 6Fh is read only.
// - The coefficient ram is 16 blocks of 8 bytes, picked by a 4-bit block selector.
// - Ram block n holds the same bytes in the same order as coefficient operation n carries.
// - A back-up copy keeps the dsp on a consistent block while single coefficients change.
// - A control register holds selector, dsp source select and start; a status register holds busy.
// - Source select 0 lets the dsp read normal blocks, 1 lets it read the temporary block.
// - Writing 1 to the start bit copies the selected block into the temporary block.
// - Busy reads 1 while the copy runs and 0 otherwise.
// - Coefficient loads through command sequences do the back-up on their own.
// - The transmit and receive agc enables act only while the speakerphone bit is 1.
// - General control holds two receive attenuations, power-up, monitoring and modified gain control bits.
// - Filter control holds separate 50 Hz high-pass disables plus gain, sidetone and correction enables.
// - Tone control holds enable, dual tone, filter, pulsed, sequence, tone mode, stop mode and shape bits.
package ccrb_pkg;
    localparam logic [7:0] ADDR_GENERAL_CONTROL = 8'h60;
    localparam logic [7:0] ADDR_FILTER_CONTROL = 8'h61;
    localparam logic [7:0] ADDR_TONE_CONTROL = 8'h62;
    localparam logic [7:0] ADDR_OUTPUT_AMP = 8'h66;
    localparam logic [7:0] ADDR_CRAM_CONTROL = 8'h6E;
    localparam logic [7:0] ADDR_CRAM_STATUS = 8'h6F;
    localparam logic [7:0] ADDR_SEQ_MULTI_TOP = 8'h67;
    localparam logic [7:0] ADDR_CRAM_BASE = 8'h80;
    localparam logic [7:0] ADDR_VOLUME_CRAM = 8'hD0;
    localparam logic [7:0] REG_RESET = 8'h00;
    // general control fields
    localparam int GC_SPEAKERPHONE_ON = 7;
    localparam int GC_TX_AGC = 6;
    localparam int GC_RX_AGC = 5;
    localparam int GC_MODIFIED_RX_GAIN_CONTROL = 4;
    localparam int GC_CONTROLLED_MONITORING_ENABLE = 3;
    localparam int GC_POWER_UP_SELECT = 2;
    localparam int GC_RX_ATTENUATION_CH2 = 1;
    localparam int GC_RX_ATTENUATION_CH1 = 0;
    // filter control fields
    localparam int FC_RX_HIGHPASS_DISABLE = 1;
    localparam int FC_TX_HIGHPASS_DISABLE = 0;
    // tone control fields
    localparam int TC_TONE_GEN_ENABLE = 7;
    // cram control and status fields
    localparam int CC_BACKUP_START = 7;
    localparam int CC_DSP_SOURCE_SELECT = 4;
    localparam int CS_BACKUP_BUSY = 0;
    // command word
    localparam int CW_READ = 7;
    localparam logic [1:0] CLS_STATUS_OPERATION = 2'h1;
    localparam logic [1:0] CLS_COEFFICIENT_OPERATION = 2'h2;
    localparam logic [1:0] CLS_EXTENDED_OPERATION = 2'h3;
    localparam logic [3:0] CODE_LOUDSPEAKER_VOLUME_SEQUENCE = 4'h6;
    localparam logic [3:0] CODE_NO_OPERATION = 4'hF;
    localparam logic [3:0] CODE_STATUS_ALL = 4'hF;
    localparam logic [3:0] LEN_ONE = 4'h1;
    localparam logic [3:0] LEN_SHORT_BLOCK = 4'h4;
    localparam logic [3:0] LEN_VOLUME = 4'h5;
    localparam logic [3:0] LEN_BLOCK = 4'h8;
    localparam logic [3:0] LEN_NONE = 4'h0;
    localparam logic [2:0] BLOCK_LAST_BYTE = 3'h7;

    typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_DATA} ccrb_seq_state_t;
endpackage

// file: src/ccrb_core.sv
// Purpose: codec configuration registers, coefficient ram, block back-up and command sequences
// Assumes: microcontroller strobes are synchronous and one cycle long
// Notes: direct port and command-sequence port share the registers; the sequence port wins on a clash
`timescale 1ns/1ns
module ccrb_core (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic seq_valid_in,
    input wire logic [7:0] seq_byte_in,
    output logic seq_ready_out,
    output logic [7:0] seq_rdata_out,
    output logic seq_rvalid_out,
    input wire logic [6:0] dsp_addr_in,
    output logic [7:0] dsp_rdata_out,
    output logic dsp_on_temp_out,
    output logic backup_busy_out,
    output logic [7:0] general_control_out,
    output logic [7:0] filter_control_out,
    output logic [7:0] tone_control_out,
    output logic tx_agc_active_out,
    output logic rx_agc_active_out
);
    import ccrb_pkg::*;

    typedef struct packed {
        logic [15:0][7:0] regs;
        logic [127:0][7:0] cram;
        logic [7:0][7:0] temp;
        logic [3:0] block_selector;
        logic dsp_source_select;
        logic cp_busy;
        logic [2:0] cp_cnt;
        logic [3:0] cp_blk;
        ccrb_seq_state_t sq_state;
        logic sq_rd;
        logic [1:0] sq_cls;
        logic [3:0] sq_code;
        logic [3:0] sq_idx;
        logic [3:0] sq_len;
        logic [3:0] sq_blk;
        logic auto_temp;
        logic on_temp;
        logic seq_ready;
        logic [7:0] seq_rdata;
        logic seq_rvalid;
        logic [7:0] rdata;
        logic [7:0] dsp_rdata;
        logic tx_agc;
        logic rx_agc;
    } ccrb_state_t;

    ccrb_state_t st_reg;
    ccrb_state_t st_next;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // data bytes after the command word
    function automatic logic [3:0] seq_len(input logic [1:0] cls, input logic [3:0] code);
        logic [3:0] n;
        n = LEN_NONE;
        case (cls)
            CLS_STATUS_OPERATION: begin
                n = (code == CODE_STATUS_ALL) ? LEN_BLOCK : LEN_ONE;
            end
            CLS_COEFFICIENT_OPERATION: begin
                if (code == 4'h3 || code == 4'h4 || code == 4'h6) begin
                    n = LEN_SHORT_BLOCK;
                end else begin
                    n = LEN_BLOCK;
                end
            end
            CLS_EXTENDED_OPERATION: begin
                n = (code == CODE_LOUDSPEAKER_VOLUME_SEQUENCE) ? LEN_VOLUME : LEN_NONE;
            end
            default: begin
                n = LEN_NONE;
            end
        endcase
        return n;
    endfunction

    // register or ram address of byte idx of a sequence
    function automatic logic [7:0] seq_addr(input logic [1:0] cls, input logic [3:0] code,
                                            input logic [3:0] idx);
        logic [7:0] a;
        a = ADDR_CRAM_BASE;
        case (cls)
            CLS_STATUS_OPERATION: begin
                if (code == CODE_STATUS_ALL) begin
                    a = ADDR_SEQ_MULTI_TOP - {4'h0, idx};
                end else begin
                    a = ADDR_GENERAL_CONTROL + {4'h0, code};
                end
            end
            CLS_COEFFICIENT_OPERATION: begin
                a = ADDR_CRAM_BASE + {1'b0, code, idx[2:0]};
            end
            CLS_EXTENDED_OPERATION: begin
                if (idx == 4'h0) begin
                    a = ADDR_OUTPUT_AMP;
                end else begin
                    a = ADDR_VOLUME_CRAM + {4'h0, idx} - 8'h01;
                end
            end
            default: begin
                a = ADDR_CRAM_BASE;
            end
        endcase
        return a;
    endfunction

    // read value of any mapped location
    function automatic logic [7:0] read_loc(input ccrb_state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a[7]) begin
            v = s.cram[a[6:0]];
        end else if (a == ADDR_CRAM_CONTROL) begin
            v = {3'h0, s.dsp_source_select, s.block_selector};
        end else if (a == ADDR_CRAM_STATUS) begin
            v = {7'h00, s.cp_busy};
        end else if (a[7:4] == ADDR_GENERAL_CONTROL[7:4]) begin
            v = s.regs[a[3:0]];
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // back-up and gating helpers

    // command words whose writes rewrite ram and so need the automatic back-up
    function automatic logic needs_backup(input logic [7:0] cw);
        logic b;
        b = 1'b0;
        if (!cw[CW_READ]) begin
            if (cw[5:4] == CLS_COEFFICIENT_OPERATION) begin
                b = 1'b1;
            end else if (cw[5:4] == CLS_EXTENDED_OPERATION && cw[3:0] == CODE_LOUDSPEAKER_VOLUME_SEQUENCE) begin
                b = 1'b1;
            end
        end
        return b;
    endfunction

    // ram block rewritten by a command word
    function automatic logic [3:0] backup_block(input logic [7:0] cw);
        logic [3:0] b;
        b = ADDR_VOLUME_CRAM[6:3];
        if (cw[5:4] == CLS_COEFFICIENT_OPERATION) begin
            b = cw[3:0];
        end
        return b;
    endfunction

    // agc enables only count while the speakerphone is on
    function automatic logic agc_gate(input logic [7:0] gc, input int en_bit);
        logic g;
        g = 1'b0;
        if (gc[GC_SPEAKERPHONE_ON]) begin
            g = gc[en_bit];
        end
        return g;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [7:0] wa;
        logic [7:0] wd;
        logic we;
        logic cp_start;
        logic [3:0] cp_src;
        logic [7:0] sa;
        logic take;
        logic need_bk;
        logic [3:0] bk_blk;
        wa = 8'h00;
        wd = 8'h00;
        we = 1'b0;
        cp_start = 1'b0;
        cp_src = st_reg.block_selector;
        sa = seq_addr(st_reg.sq_cls, st_reg.sq_code, st_reg.sq_idx);
        take = 1'b0;
        need_bk = 1'b0;
        bk_blk = 4'h0;
        st_next = st_reg;
        st_next.seq_rvalid = 1'b0;

        // command sequence port
        case (st_reg.sq_state)
            SQ_IDLE: begin
                if (seq_valid_in && st_reg.seq_ready) begin
                    st_next.sq_rd = seq_byte_in[CW_READ];
                    st_next.sq_cls = seq_byte_in[5:4];
                    st_next.sq_code = seq_byte_in[3:0];
                    st_next.sq_len = seq_len(seq_byte_in[5:4], seq_byte_in[3:0]);
                    st_next.sq_idx = 4'h0;
                    need_bk = needs_backup(seq_byte_in);
                    bk_blk = backup_block(seq_byte_in);
                    st_next.sq_blk = bk_blk;
                    if (seq_len(seq_byte_in[5:4], seq_byte_in[3:0]) == LEN_NONE) begin
                        st_next.sq_state = SQ_IDLE;
                    end else if (need_bk) begin
                        // dsp must see the old block while the sequence rewrites it
                        st_next.sq_state = SQ_WAIT;
                        st_next.seq_ready = 1'b0;
                    end else begin
                        st_next.sq_state = SQ_DATA;
                    end
                end
            end
            SQ_WAIT: begin
                // start the copy once, then wait for it to drain before taking data
                if (!st_reg.cp_busy && !st_reg.auto_temp) begin
                    cp_start = 1'b1;
                    cp_src = st_reg.sq_blk;
                    st_next.auto_temp = 1'b1;
                end else if (!st_reg.cp_busy) begin
                    st_next.sq_state = SQ_DATA;
                    st_next.seq_ready = 1'b1;
                end
            end
            SQ_DATA: begin
                if (seq_valid_in && st_reg.seq_ready) begin
                    take = 1'b1;
                    if (st_reg.sq_rd) begin
                        st_next.seq_rdata = read_loc(st_reg, sa);
                        st_next.seq_rvalid = 1'b1;
                    end else begin
                        wa = sa;
                        wd = seq_byte_in;
                        we = 1'b1;
                    end
                    st_next.sq_idx = st_reg.sq_idx + 4'h1;
                    if (st_reg.sq_idx == st_reg.sq_len - 4'h1) begin
                        st_next.sq_state = SQ_IDLE;
                        st_next.auto_temp = 1'b0;
                    end
                end
            end
            default: begin
                st_next.sq_state = SQ_IDLE;
                st_next.seq_ready = 1'b1;
            end
        endcase

        // direct port; a clash with a sequence byte drops the direct write
        if (wr_in && !take) begin
            wa = addr_in;
            wd = wdata_in;
            we = 1'b1;
        end
        if (rd_in) begin
            st_next.rdata = read_loc(st_reg, addr_in);
        end

        // single write decode
        if (we) begin
            if (wa[7]) begin
                // ram writes during a copy would tear the block, so they are dropped
                if (!st_reg.cp_busy) begin
                    st_next.cram[wa[6:0]] = wd;
                end
            end else if (wa == ADDR_CRAM_CONTROL) begin
                st_next.block_selector = wd[3:0];
                st_next.dsp_source_select = wd[CC_DSP_SOURCE_SELECT];
                if (wd[CC_BACKUP_START] && !st_reg.cp_busy && !cp_start) begin
                    cp_start = 1'b1;
                    cp_src = wd[3:0];
                end
            end else if (wa[7:4] == ADDR_GENERAL_CONTROL[7:4] && wa != ADDR_CRAM_STATUS) begin
                st_next.regs[wa[3:0]] = wd;
            end
        end

        // block copy engine, one byte per cycle
        if (cp_start) begin
            st_next.cp_busy = 1'b1;
            st_next.cp_cnt = 3'h0;
            st_next.cp_blk = cp_src;
        end else if (st_reg.cp_busy) begin
            st_next.temp[st_reg.cp_cnt] = st_reg.cram[{st_reg.cp_blk, st_reg.cp_cnt}];
            st_next.cp_cnt = st_reg.cp_cnt + 3'h1;
            if (st_reg.cp_cnt == BLOCK_LAST_BYTE) begin
                st_next.cp_busy = 1'b0;
            end
        end

        // dsp read port
        if (st_reg.on_temp) begin
            st_next.dsp_rdata = st_reg.temp[dsp_addr_in[2:0]];
        end else begin
            st_next.dsp_rdata = st_reg.cram[dsp_addr_in];
        end

        // agc only with speakerphone on
        st_next.tx_agc = agc_gate(st_next.regs[4'h0], GC_TX_AGC);
        st_next.rx_agc = agc_gate(st_next.regs[4'h0], GC_RX_AGC);

        // source flag kept in its own flop so the pin needs no gate after the register
        // it follows the select bit and the automatic back-up together, with no extra lag
        st_next.on_temp = st_next.dsp_source_select || st_next.auto_temp;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
            st_reg.sq_state <= SQ_IDLE;
            st_reg.seq_ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rdata_out = st_reg.rdata;
    assign seq_ready_out = st_reg.seq_ready;
    assign seq_rdata_out = st_reg.seq_rdata;
    assign seq_rvalid_out = st_reg.seq_rvalid;
    assign dsp_rdata_out = st_reg.dsp_rdata;
    assign dsp_on_temp_out = st_reg.on_temp;
    assign backup_busy_out = st_reg.cp_busy;
    assign general_control_out = st_reg.regs[ADDR_GENERAL_CONTROL[3:0]];
    assign filter_control_out = st_reg.regs[ADDR_FILTER_CONTROL[3:0]];
    assign tone_control_out = st_reg.regs[ADDR_TONE_CONTROL[3:0]];
    assign tx_agc_active_out = st_reg.tx_agc;
    assign rx_agc_active_out = st_reg.rx_agc;
endmodule

// file: tb/ccrb_core_asserts.sv
// Purpose: port checker of the coefficient ram block
// Assumes: one clock, synchronous active low reset
// Notes: status reserved bits taken to read zero
`timescale 1ns/1ns
module ccrb_core_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic seq_valid_in,
    input wire logic dsp_on_temp_out,
    input wire logic backup_busy_out,
    input wire logic [7:0] general_control_out,
    input wire logic tx_agc_active_out,
    input wire logic rx_agc_active_out
);
    import ccrb_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////
    sequence busy_run;
        backup_busy_out [*8] ##1 !backup_busy_out;
    endsequence
    // a clashing sequence byte may win, so only quiet cycles count
    sequence ctl_wr;
        wr_in && !seq_valid_in && addr_in == ADDR_CRAM_CONTROL;
    endsequence
    chk_busy_eight: assert property ($rose(backup_busy_out) |-> busy_run)
        else $error("busy width wrong");
    chk_start_busy: assert property (ctl_wr ##0 (wdata_in[7] && !backup_busy_out) |=> backup_busy_out)
        else $error("start did not raise busy");
    chk_src_temp: assert property (ctl_wr ##0 wdata_in[4] |=> dsp_on_temp_out)
        else $error("source select ignored");
    chk_gc_write: assert property (wr_in && !seq_valid_in && addr_in == 8'h60
        |=> general_control_out == $past(wdata_in))
        else $error("general control not stored");
    chk_tx_agc: assert property (tx_agc_active_out == (general_control_out[7] && general_control_out[6]))
        else $error("tx agc gating wrong");
    chk_rx_agc: assert property (rx_agc_active_out == (general_control_out[7] && general_control_out[5]))
        else $error("rx agc gating wrong");
    chk_status_read: assert property (rd_in && addr_in == 8'h6F
        |=> rdata_out == {7'h00, $past(backup_busy_out)})
        else $error("status read wrong");
    chk_unmapped_read: assert property (rd_in && (addr_in < 8'h60 || addr_in[7:4] == 4'h7)
        |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!rd_in |=> $stable(rdata_out))
        else $error("read data moved");
endmodule
////////////////////////////////////////
bind ccrb_core ccrb_core_asserts chk_u (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .seq_valid_in, .dsp_on_temp_out, .backup_busy_out, .general_control_out,
    .tx_agc_active_out, .rx_agc_active_out);

// file: tb/ccrb_mcu_model.sv
// Purpose: microcontroller model on the register and sequence ports
// Assumes: drives at the falling edge
// Notes: rude lets a scenario touch ram while busy on purpose
`timescale 1ns/1ns
module ccrb_mcu_model (
    input wire logic clk_in,
    input wire logic busy_in,
    input wire logic ready_in,
    input wire logic [7:0] rdata_in,
    input wire logic [7:0] dsp_rdata_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    output logic seq_valid_out,
    output logic [7:0] seq_byte_out,
    output logic [6:0] dsp_addr_out
);
    logic rude = 1'b0;
    initial begin
        {addr_out, wdata_out, wr_out, rd_out, seq_valid_out, seq_byte_out, dsp_addr_out} = '0;
    end
    ////////////////////////////////////////
    task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clk_in);
        for (int i = 0; i < 30 && a[7] && busy_in && !rude; i++) @(negedge clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = w;
        rd_out = !w;
        @(negedge clk_in);
        wr_out = 1'b0;
        rd_out = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(a, d, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cyc(a, 8'h00, 1'b0);
        d = rdata_in;
    endtask
    task automatic sb(input logic [7:0] b);
        @(negedge clk_in);
        seq_byte_out = b;
        seq_valid_out = 1'b1;
        repeat (40) begin
            @(posedge clk_in);
            if (ready_in) break;
        end
        @(negedge clk_in);
        seq_valid_out = 1'b0;
    endtask
    task automatic dsp(input logic [6:0] a, output logic [7:0] d);
        @(negedge clk_in);
        dsp_addr_out = a;
        @(negedge clk_in);
        d = dsp_rdata_in;
    endtask
endmodule

// file: tb/codec_coefficient_ram_backup_tb.sv
// Purpose: self-checking bench of the coefficient ram block
// Assumes: model tasks end at a falling edge
// Notes: run is a few hundred cycles
`timescale 1ns/1ns
module codec_coefficient_ram_backup_tb;
    import ccrb_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr_in, wdata_in, rdata_out, seq_byte_in, seq_rdata_out, dsp_rdata_out, gc, fc, tc, v;
    logic wr_in, rd_in, seq_valid_in, seq_ready_out, seq_rvalid_out, dsp_on_temp_out, busy, txa, rxa;
    logic [6:0] dsp_addr_in;
    logic [7:0] q[$];
    int errors = 0;
    int num_checks = 0;
    always #5 clk_in = ~clk_in;
    ccrb_core dut_u (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .seq_valid_in,
        .seq_byte_in, .seq_ready_out, .seq_rdata_out, .seq_rvalid_out, .dsp_addr_in, .dsp_rdata_out,
        .dsp_on_temp_out, .backup_busy_out(busy), .general_control_out(gc), .filter_control_out(fc),
        .tone_control_out(tc), .tx_agc_active_out(txa), .rx_agc_active_out(rxa));
    ccrb_mcu_model mc_u (.clk_in, .busy_in(busy), .ready_in(seq_ready_out), .rdata_in(rdata_out),
        .dsp_rdata_in(dsp_rdata_out), .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in),
        .rd_out(rd_in), .seq_valid_out(seq_valid_in), .seq_byte_out(seq_byte_in), .dsp_addr_out(dsp_addr_in));
    always @(negedge clk_in) if (seq_rvalid_out === 1'b1) q.push_back(seq_rdata_out);
    ////////////////////////////////////////
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] exp);
        mc_u.rd(a, v);
        check(n, v, exp);
    endtask
    initial begin
        #200000;
        errors++;
        test_done;
    end
    ////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        check("reset ready", {7'h00, seq_ready_out}, 8'h01);
        rdc("reset status", ADDR_CRAM_STATUS, REG_RESET);
        for (int i = 0; i < 14; i++) begin
            mc_u.wr(8'h60 + 8'(i), 8'hA5 ^ 8'(i));
            rdc("config", 8'h60 + 8'(i), 8'hA5 ^ 8'(i));
        end
        check("general", gc, 8'hA5);
        check("filter", fc, 8'hA4);
        check("tone", tc, 8'hA7);
        check("agc a5", {6'h00, txa, rxa}, 8'h01);
        mc_u.wr(8'h60, 8'h60);
        check("agc off", {6'h00, txa, rxa}, 8'h00);
        mc_u.wr(8'h60, 8'hC0);
        check("agc tx", {6'h00, txa, rxa}, 8'h02);
        mc_u.wr(ADDR_CRAM_STATUS, 8'hFF);
        rdc("status ro", ADDR_CRAM_STATUS, 8'h00);
        rdc("unmapped lo", 8'h5F, 8'h00);
        rdc("unmapped hi", 8'h70, 8'h00);
        for (int k = 0; k < 8; k++) mc_u.wr(8'h98 + 8'(k), 8'h30 + 8'(k));
        mc_u.wr(ADDR_CRAM_CONTROL, 8'h83);
        check("busy", {7'h00, busy}, 8'h01);
        rdc("busy read", ADDR_CRAM_STATUS, 8'h01);
        mc_u.wr(ADDR_CRAM_CONTROL, 8'h83);
        for (int i = 0; i < 20 && busy; i++) @(negedge clk_in);
        rdc("idle read", ADDR_CRAM_STATUS, 8'h00);
        rdc("control", ADDR_CRAM_CONTROL, 8'h03);
        mc_u.wr(ADDR_CRAM_CONTROL, 8'h13);
        check("on temp", {7'h00, dsp_on_temp_out}, 8'h01);
        mc_u.wr(8'h98, 8'h55);
        for (int k = 0; k < 8; k++) begin
            mc_u.dsp(7'h18 + 7'(k), v);
            check("temp byte", v, 8'h30 + 8'(k));
        end
        mc_u.wr(ADDR_CRAM_CONTROL, 8'h03);
        mc_u.dsp(7'h18, v);
        check("normal", v, 8'h55);
        mc_u.rude = 1'b1;
        mc_u.wr(ADDR_CRAM_CONTROL, 8'h83);
        mc_u.wr(8'h98, 8'hAA);
        mc_u.rude = 1'b0;
        rdc("busy drop", 8'h98, 8'h55);
        mc_u.sb(8'h20);
        check("auto ready", {7'h00, seq_ready_out}, 8'h00);
        for (int k = 0; k < 8; k++) begin
            mc_u.sb(8'h10 + 8'(k));
            check("auto temp", {7'h00, dsp_on_temp_out}, (k < 7) ? 8'h01 : 8'h00);
            if (k == 3) begin
                mc_u.dsp(7'h01, v);
                check("auto old", v, 8'h00);
            end
        end
        for (int k = 0; k < 8; k++) rdc("cop ram", 8'h80 + 8'(k), 8'h10 + 8'(k));
        q.delete();
        mc_u.sb(8'hA0);
        repeat (8) mc_u.sb(8'h00);
        repeat (2) @(negedge clk_in);
        check("cop count", 8'(q.size()), 8'h08);
        for (int k = 0; k < 8 && k < q.size(); k++) check("cop read", q[k], 8'h10 + 8'(k));
        mc_u.sb(8'h10);
        mc_u.sb(8'h5A);
        check("sop write", gc, 8'h5A);
        mc_u.sb(8'h90);
        mc_u.sb(8'h00);
        repeat (2) @(negedge clk_in);
        check("sop read", q[$], 8'h5A);
        mc_u.sb(8'h36);
        for (int k = 0; k < 5; k++) mc_u.sb(8'hE0 + 8'(k));
        rdc("vol amp", ADDR_OUTPUT_AMP, 8'hE0);
        for (int k = 0; k < 4; k++) rdc("vol ram", ADDR_VOLUME_CRAM + 8'(k), 8'hE1 + 8'(k));
        mc_u.sb(8'h3F);
        mc_u.sb(8'h10);
        mc_u.sb(8'h77);
        check("after nop", gc, 8'h77);
        test_done;
    end
endmodule
